/* src/rss_sequencer.sv */
// Reset source sequencer: merges pin, watchdog and wake-up resets.
module rss_sequencer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reset_pin_in,
    input wire logic watchdog_overflow,
    input wire logic wake_event,
    input wire logic power_down,
    output logic reset_pin_out,
    output logic reset_pin_oe,
    output logic core_reset,
    output logic bus_ctrl_reset,
    output logic addr_latch_strobe_force,
    output logic program_store_strobe_force,
    output logic machine_tick,
    output logic [7:0] port_latch_reset,
    output logic [7:0] stack_pointer_reset,
    output logic [7:0] clear_reset
);
    logic [3:0] osc_count;
    logic mc_tick;
    logic pin_meta;
    logic pin_sync;
    logic [13:0] pin_mc;
    logic pin_reset;
    logic wdt_start;
    logic wake_start;
    logic wdt_active;
    logic wake_active;
    logic wdt_pending;
    logic wake_pending;
    logic wake_hold;
    rss_pkg::rss_state_t state;
    logic any_reset;

    // Machine cycle enable from the oscillator clock.
    always_ff @(posedge mclk) begin
        if (rst) begin
            osc_count <= 4'h0;
        end else if (osc_count == rss_pkg::MC_LAST) begin
            osc_count <= 4'h0;
        end else begin
            osc_count <= osc_count + 4'h1;
        end
    end

    assign mc_tick = (osc_count == rss_pkg::MC_LAST);

    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_meta <= 1'b0;
            pin_sync <= 1'b0;
        end else begin
            pin_meta <= reset_pin_in;
            pin_sync <= pin_meta;
        end
    end

    // Counts machine-cycle ticks seen while the synced pin is high; saturates past the bus threshold.
    always_ff @(posedge mclk) begin
        if (rst) begin
            pin_mc <= 14'h0000;
        end else if (!pin_sync) begin
            pin_mc <= 14'h0000;
        end else if (mc_tick && pin_mc != 14'h3fff) begin
            pin_mc <= pin_mc + 14'h0001;
        end
    end

    // The tick that completes the second machine cycle already counts, so a pin held
    // for exactly two machine cycles is never missed whatever the tick phase.
    assign pin_reset = pin_sync && ((pin_mc >= rss_pkg::PIN_MIN_MC)
        || (mc_tick && pin_mc == rss_pkg::PIN_MIN_MC - 14'h0001));

    // Requests wait for the next machine-cycle boundary before starting a pulse.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wdt_pending <= 1'b0;
        end else if (watchdog_overflow) begin
            wdt_pending <= 1'b1;
        end else if (mc_tick) begin
            wdt_pending <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_pending <= 1'b0;
        end else if (wake_event && power_down) begin
            wake_pending <= 1'b1;
        end else if (mc_tick) begin
            wake_pending <= 1'b0;
        end
    end

    // Remembers that the pin is high because of our own wake pulse, until the synced
    // pin has fallen again, so the tail of the pulse cannot reset the bus controller.
    always_ff @(posedge mclk) begin
        if (rst) begin
            wake_hold <= 1'b0;
        end else if (wake_start) begin
            wake_hold <= 1'b1;
        end else if (!pin_sync && !wake_active) begin
            wake_hold <= 1'b0;
        end
    end

    assign wdt_start = mc_tick && wdt_pending && !wake_active;
    assign wake_start = mc_tick && wake_pending;

    rss_pulse_timer wdt_timer (
        .mclk(mclk),
        .rst(rst),
        .mc_tick(mc_tick),
        .start(wdt_start),
        .length(rss_pkg::WDT_MC),
        .active(wdt_active)
    );

    rss_pulse_timer wake_timer (
        .mclk(mclk),
        .rst(rst),
        .mc_tick(mc_tick),
        .start(wake_start),
        .length(rss_pkg::WAKE_MC),
        .active(wake_active)
    );

    // Tracks which internal source owns the reset line.
    always_ff @(posedge mclk) begin
        if (rst) begin
            state <= rss_pkg::RSS_IDLE;
        end else begin
            case (state)
                rss_pkg::RSS_IDLE: begin
                    if (wake_start) begin
                        state <= rss_pkg::RSS_WAKE;
                    end else if (wdt_start) begin
                        state <= rss_pkg::RSS_WDT;
                    end
                end
                rss_pkg::RSS_WDT: begin
                    if (wake_start) begin
                        state <= rss_pkg::RSS_WAKE;
                    end else if (!wdt_active && !wdt_start) begin
                        state <= rss_pkg::RSS_IDLE;
                    end
                end
                rss_pkg::RSS_WAKE: begin
                    if (!wake_active && !wake_start) begin
                        state <= rss_pkg::RSS_IDLE;
                    end
                end
                default: begin
                    state <= rss_pkg::RSS_IDLE;
                end
            endcase
        end
    end

    // Internal pulses act without regard to the pin level.
    assign any_reset = wdt_active || wake_active || pin_reset;

    always_ff @(posedge mclk) begin
        if (rst) begin
            reset_pin_out <= 1'b1;
            reset_pin_oe <= 1'b0;
        end else begin
            reset_pin_out <= 1'b1;
            reset_pin_oe <= wdt_active || wake_active;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            core_reset <= 1'b1;
        end else begin
            core_reset <= any_reset;
        end
    end

    // Only a pin reset resets the bus controller; a long stretched wake pulse counts too.
    always_ff @(posedge mclk) begin
        if (rst) begin
            bus_ctrl_reset <= 1'b1;
        end else begin
            bus_ctrl_reset <= pin_reset && !(wake_hold && pin_mc < rss_pkg::BUS_RST_MC);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            addr_latch_strobe_force <= 1'b1;
            program_store_strobe_force <= 1'b1;
        end else begin
            addr_latch_strobe_force <= any_reset;
            program_store_strobe_force <= any_reset;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            machine_tick <= 1'b0;
        end else begin
            machine_tick <= mc_tick;
        end
    end

    // Load values for reset-loaded registers; RAM and undefined registers get no load at all.
    always_ff @(posedge mclk) begin
        if (rst) begin
            port_latch_reset <= rss_pkg::PORT_RESET;
            stack_pointer_reset <= rss_pkg::SP_RESET;
            clear_reset <= rss_pkg::REG_RESET;
        end else begin
            port_latch_reset <= rss_pkg::PORT_RESET;
            stack_pointer_reset <= rss_pkg::SP_RESET;
            clear_reset <= rss_pkg::REG_RESET;
        end
    end
endmodule : rss_sequencer

/* src/rss_pkg.sv */
// Constants and types shared by the reset source sequencer.
package rss_pkg;
    localparam int unsigned MC_DIV = 12;
    localparam logic [3:0] MC_LAST = 4'hb;
    localparam logic [13:0] PIN_MIN_MC = 14'h0002;
    localparam logic [13:0] WDT_MC = 14'h0003;
    localparam logic [13:0] WAKE_MC = 14'h1800;
    localparam logic [13:0] BUS_RST_MC = 14'h2000;
    localparam logic [7:0] PORT_RESET = 8'hff;
    localparam logic [7:0] SP_RESET = 8'h07;
    localparam logic [7:0] REG_RESET = 8'h00;

    typedef enum logic [1:0] {
        RSS_IDLE = 2'b00,
        RSS_WDT = 2'b01,
        RSS_WAKE = 2'b10
    } rss_state_t;
endpackage : rss_pkg

/* src/rss_pulse_timer.sv */
// Machine-cycle pulse counter used for the internal reset pulses.
module rss_pulse_timer (
    input wire logic mclk,
    input wire logic rst,
    input wire logic mc_tick,
    input wire logic start,
    input wire logic [13:0] length,
    output logic active
);
    logic [13:0] remaining;

    always_ff @(posedge mclk) begin
        if (rst) begin
            remaining <= 14'h0000;
        end else if (start) begin
            remaining <= length;
        end else if (mc_tick && remaining != 14'h0000) begin
            remaining <= remaining - 14'h0001;
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            active <= 1'b0;
        end else begin
            active <= start || (remaining > 14'h0001) || (remaining == 14'h0001 && !mc_tick);
        end
    end
endmodule : rss_pulse_timer

/* verif/rss_sequencer_sva.sv */
// Port checker for the reset source sequencer.
module rss_sequencer_sva (
    input wire logic mclk,
    input wire logic rst,
    input wire logic reset_pin_in,
    input wire logic watchdog_overflow,
    input wire logic reset_pin_out,
    input wire logic reset_pin_oe,
    input wire logic core_reset,
    input wire logic bus_ctrl_reset,
    input wire logic addr_latch_strobe_force,
    input wire logic program_store_strobe_force,
    input wire logic machine_tick,
    input wire logic [7:0] port_latch_reset,
    input wire logic [7:0] stack_pointer_reset,
    input wire logic [7:0] clear_reset
);
    logic [16:0] oe_len;
    logic [5:0] pin_len;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);
    always_ff @(posedge mclk) begin
        if (rst || !reset_pin_oe) begin
            oe_len <= 17'h0;
        end else begin
            oe_len <= oe_len + 17'h1;
        end
    end
    // Counts consecutive high cycles on the pin and saturates at 40.
    always_ff @(posedge mclk) begin
        if (rst || !reset_pin_in) begin
            pin_len <= 6'h0;
        end else if (pin_len != 6'h28) begin
            pin_len <= pin_len + 6'h1;
        end
    end
    sequence wdt_req;
        watchdog_overflow && !reset_pin_oe;
    endsequence
    sequence oe_rise;
        ##[1:16] reset_pin_oe;
    endsequence
    ale_force_a: assert property (addr_latch_strobe_force == core_reset)
        else $error("address latch strobe force differs from core reset");
    pse_force_a: assert property (program_store_strobe_force == core_reset)
        else $error("program store strobe force differs from core reset");
    tick_period_a: assert property (machine_tick |-> ##12 machine_tick)
        else $error("machine tick period is not 12 clocks");
    tick_gap_a: assert property (machine_tick |=> !machine_tick [*8])
        else $error("machine tick repeats too early");
    wdt_resp_a: assert property (wdt_req |-> oe_rise)
        else $error("watchdog overflow gave no reset pulse");
    pulse_len_a: assert property ($fell(reset_pin_oe) |-> oe_len == 17'h00024 || oe_len == 17'h12000)
        else $error("internal reset pulse has a wrong length");
    pin_drive_a: assert property (reset_pin_oe |-> reset_pin_out && core_reset)
        else $error("pin pulse without high drive or core reset");
    pin_reset_a: assert property (pin_len == 6'h28 |-> core_reset)
        else $error("held reset pin gave no core reset");
    bus_quiet_a: assert property (!reset_pin_in [*8] |-> !bus_ctrl_reset)
        else $error("bus controller reset without pin reset");
    strap_vals_a: assert property (port_latch_reset == 8'hff && stack_pointer_reset == 8'h07
        && clear_reset == 8'h00)
        else $error("reset load values are wrong");
endmodule : rss_sequencer_sva

bind rss_sequencer rss_sequencer_sva u_sva (.mclk(mclk), .rst(rst), .reset_pin_in(reset_pin_in),
    .watchdog_overflow(watchdog_overflow), .reset_pin_out(reset_pin_out),
    .reset_pin_oe(reset_pin_oe), .core_reset(core_reset), .bus_ctrl_reset(bus_ctrl_reset),
    .addr_latch_strobe_force(addr_latch_strobe_force), .machine_tick(machine_tick),
    .program_store_strobe_force(program_store_strobe_force), .clear_reset(clear_reset),
    .port_latch_reset(port_latch_reset), .stack_pointer_reset(stack_pointer_reset));

/* verif/rss_reset_line.sv */
// Outside reset circuitry sharing the reset line with the device.
module rss_reset_line (
    input wire logic ext_hold,
    input wire logic dev_oe,
    input wire logic dev_out,
    output logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    // The line has a pull-down, so it reads low once nobody drives it high.
    assign pin = ext_hold | (dev_oe & dev_out);
endmodule : rss_reset_line

/* verif/tb_reset_source_sequencer.sv */
// Self-checking bench for the reset source sequencer.
module tb_reset_source_sequencer;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 0, rst = 1, ext_hold = 0, watchdog_overflow = 0, wake_event = 0, power_down = 0;
    logic reset_pin_in, reset_pin_out, reset_pin_oe, core_reset, bus_ctrl_reset, ale, pse, tick;
    logic [7:0] port_latch_reset, stack_pointer_reset, clear_reset;
    int mismatches = 0, comparisons = 0, n;
    logic bus_seen;
    initial forever #4 mclk = ~mclk;
    rss_reset_line partner (.ext_hold(ext_hold), .dev_oe(reset_pin_oe), .dev_out(reset_pin_out),
        .pin(reset_pin_in));
    rss_sequencer DUT (.mclk(mclk), .rst(rst), .reset_pin_in(reset_pin_in),
        .watchdog_overflow(watchdog_overflow), .wake_event(wake_event), .power_down(power_down),
        .reset_pin_out(reset_pin_out), .reset_pin_oe(reset_pin_oe), .core_reset(core_reset),
        .bus_ctrl_reset(bus_ctrl_reset), .addr_latch_strobe_force(ale),
        .program_store_strobe_force(pse), .machine_tick(tick), .clear_reset(clear_reset),
        .port_latch_reset(port_latch_reset), .stack_pointer_reset(stack_pointer_reset));
    task check(input string what, input logic [16:0] seen, input logic [16:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    task test_done;
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    task wait_for(input logic core, input logic lvl, input int bound);
        int i;
        for (i = 0; i < bound && (core ? core_reset : reset_pin_oe) !== lvl; i++) @(negedge mclk);
        if (i == bound) begin
            mismatches++;
            $display("MISMATCH wait level expected %b seen timeout", lvl);
            test_done();
        end
    endtask : wait_for
    task count_oe;
        n = 0;
        bus_seen = 0;
        while (reset_pin_oe === 1'b1 && n < 80000) begin
            n++;
            bus_seen |= bus_ctrl_reset;
            @(negedge mclk);
        end
    endtask : count_oe
    task pulse(input logic wdt);
        if (wdt) watchdog_overflow = 1;
        else wake_event = 1;
        @(negedge mclk);
        watchdog_overflow = 0;
        wake_event = 0;
    endtask : pulse
    task t_reset;
        check("core reset", core_reset, 1);
        check("bus reset", bus_ctrl_reset, 1);
        check("strobes", {ale, pse}, 3);
        check("pin drive", reset_pin_oe, 0);
        rst = 0;
        repeat (3) @(negedge mclk);
        check("loads", {port_latch_reset, stack_pointer_reset}, 17'h0ff07);
        check("clear", clear_reset, 0);
        $display("test reset done");
    endtask : t_reset
    task t_pin;
        ext_hold = 1;
        repeat (24) @(negedge mclk);
        ext_hold = 0;
        wait_for(1, 1, 20);
        check("bus reset", bus_ctrl_reset, 1);
        check("strobes", {ale, pse}, 3);
        wait_for(1, 0, 40);
        $display("test pin done");
    endtask : t_pin
    task t_wdt;
        pulse(1);
        wait_for(0, 1, 20);
        count_oe();
        check("watchdog pulse", 17'(n), 17'h00024);
        wait_for(1, 0, 60);
        $display("test watchdog done");
    endtask : t_wdt
    task t_wake;
        pulse(0);
        repeat (30) @(negedge mclk);
        check("wake without power-down", reset_pin_oe, 0);
        power_down = 1;
        pulse(0);
        wait_for(0, 1, 30);
        repeat (100) @(negedge mclk);
        pulse(1);
        count_oe();
        check("wake pulse", 17'(n + 101), 17'h12000);
        // The synced pin falls two clocks after the pulse ends; the bus reset must stay low then too.
        repeat (8) begin
            bus_seen |= bus_ctrl_reset;
            @(negedge mclk);
        end
        check("bus reset in wake", bus_seen, 0);
        power_down = 0;
        wait_for(1, 0, 60);
        $display("test wake done");
    endtask : t_wake
    initial begin
        repeat (10) @(negedge mclk);
        t_reset();
        t_pin();
        t_wdt();
        t_wake();
        test_done();
    end
endmodule : tb_reset_source_sequencer
